// [hdl/tmr8_pkg.sv]
// Functional notes
// [RQ1] force strobes act only in non-PWM modes
// [RQ2] force strobe applies compare action immediately
// [RQ3] forced compare sets no flag, no clear
// [RQ4] force bits always read back zero
// [RQ5] software writes zero force bits in PWM
// [RQ6] select 0 stop, 1 direct, 2-5 prescaled
// [RQ7] select 6 falling, 7 rising pin edges
// [RQ8] pin edges count even when pin outputs
// [RQ9] counter readable and writable by software
// [RQ10] counter write blocks next tick's match
// [RQ11] compare values matched continuously against counter
// [RQ12] reserved bits read as zero
// [RQ13] match B request: enable, global, flag
// [RQ14] match A request: enable, global, flag
// [RQ15] overflow request: enable, global, flag
// [RQ16] match B flag sets, clears ack/one
// [RQ17] match A flag sets, clears ack/one
// [RQ18] overflow flag sets, clears ack/one
// [RQ19] overflow point depends on waveform mode
// [RQ20] overflow at MAX, BOTTOM or top
// [RQ21] counter steps per tick, holds when stopped
// [RQ22] acknowledge pulse clears its flag
package tmr8_pkg;

  // ==========================================================
  // register offsets
  localparam logic [7:0] OFS_CTRL_A = 8'h44;
  localparam logic [7:0] OFS_CTRL_B = 8'h45;
  localparam logic [7:0] OFS_COUNT  = 8'h46;
  localparam logic [7:0] OFS_CMP_A  = 8'h47;
  localparam logic [7:0] OFS_CMP_B  = 8'h48;
  localparam logic [7:0] OFS_MASK   = 8'h6e;
  localparam logic [7:0] OFS_FLAGS  = 8'h35;
  localparam logic [7:0] REG_RESET  = 8'h00;

  // ==========================================================
  // field positions
  localparam int FOC_A_BIT  = 7;
  localparam int FOC_B_BIT  = 6;
  localparam int WGM2_BIT   = 3;
  localparam int CS_LSB     = 0;
  localparam int ACT_A_LSB  = 6;
  localparam int ACT_B_LSB  = 4;
  localparam int WGM10_LSB  = 0;
  localparam int OVF_BIT    = 0;
  localparam int MA_BIT     = 1;
  localparam int MB_BIT     = 2;

  // ==========================================================
  // clock select codes and prescaler masks
  localparam logic [2:0] CS_STOP   = 3'h0;
  localparam logic [2:0] CS_DIRECT = 3'h1;
  localparam logic [2:0] CS_DIV8   = 3'h2;
  localparam logic [2:0] CS_DIV64  = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1K  = 3'h5;
  localparam logic [2:0] CS_FALL   = 3'h6;
  localparam logic [2:0] CS_RISE   = 3'h7;
  localparam logic [9:0] PRE_M8    = 10'h007;
  localparam logic [9:0] PRE_M64   = 10'h03f;
  localparam logic [9:0] PRE_M256  = 10'h0ff;
  localparam logic [9:0] PRE_M1K   = 10'h3ff;

  // ==========================================================
  // waveform modes, count limits, output actions
  localparam logic [2:0] WGM_CTC      = 3'h2;
  localparam logic [2:0] WGM_PC_OCRA  = 3'h5;
  localparam logic [2:0] WGM_FP_OCRA  = 3'h7;
  localparam logic [7:0] CNT_MAX      = 8'hff;
  localparam logic [7:0] CNT_BOTTOM   = 8'h00;
  localparam logic [1:0] ACT_OFF      = 2'h0;
  localparam logic [1:0] ACT_TOGGLE   = 2'h1;
  localparam logic [1:0] ACT_CLEAR    = 2'h2;
  localparam logic [1:0] ACT_SET      = 2'h3;

  typedef enum logic {TMR8_UP, TMR8_DOWN} tmr8_dir_t;

endpackage : tmr8_pkg

// [hdl/tmr8_prescale.sv]
`timescale 1ns/100ps
module tmr8_prescale (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic [2:0] clk_source_sel,
  input  wire logic       ext_count_pin,
  output logic            tick
);

  logic [9:0] pre_q;
  logic       pin_s1_q;
  logic       pin_s2_q;
  logic       pin_s3_q;
  wire        pin_fall;
  wire        pin_rise;

  // ==========================================================
  // free running divider
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= 10'h000;
    end else if (clk_en) begin
      pre_q <= pre_q + 10'h001;
    end
  end

  // ==========================================================
  // pin synchroniser and edge detector; the pin is sampled even while driven as output
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
    end else if (clk_en) begin
      pin_s1_q <= ext_count_pin; // RQ8
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  assign pin_fall = pin_s3_q & ~pin_s2_q; // RQ7
  assign pin_rise = ~pin_s3_q & pin_s2_q; // RQ7

  // ==========================================================
  // tick selection
  always_comb begin
    unique case (clk_source_sel) // RQ6
      tmr8_pkg::CS_STOP:   tick = 1'b0;
      tmr8_pkg::CS_DIRECT: tick = 1'b1;
      tmr8_pkg::CS_DIV8:   tick = (pre_q & tmr8_pkg::PRE_M8) == tmr8_pkg::PRE_M8;
      tmr8_pkg::CS_DIV64:  tick = (pre_q & tmr8_pkg::PRE_M64) == tmr8_pkg::PRE_M64;
      tmr8_pkg::CS_DIV256: tick = (pre_q & tmr8_pkg::PRE_M256) == tmr8_pkg::PRE_M256;
      tmr8_pkg::CS_DIV1K:  tick = (pre_q & tmr8_pkg::PRE_M1K) == tmr8_pkg::PRE_M1K;
      tmr8_pkg::CS_FALL:   tick = pin_fall;
      tmr8_pkg::CS_RISE:   tick = pin_rise;
    endcase
  end

endmodule : tmr8_prescale

// [hdl/tmr8_top.sv]
`timescale 1ns/100ps
module tmr8_top (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       clk_en,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       ext_count_pin,
  input  wire logic       global_irq_en,
  input  wire logic       ack_overflow,
  input  wire logic       ack_match_a,
  input  wire logic       ack_match_b,
  output logic            irq_overflow,
  output logic            irq_match_a,
  output logic            irq_match_b,
  output logic            wave_out_a,
  output logic            wave_out_b,
  output logic            wave_oe_a,
  output logic            wave_oe_b
);

  // ==========================================================
  // reset release
  logic rst_s1_q;
  logic rst_n;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // ==========================================================
  // state
  logic [1:0]          out_action_a;
  logic [1:0]          out_action_b;
  logic [1:0]          wave_mode_lo;
  logic                wave_mode_bit2;
  logic [2:0]          clk_source_sel;
  logic [7:0]          timer_count;
  logic [7:0]          compare_value_a;
  logic [7:0]          compare_value_b;
  logic                match_b_irq_en;
  logic                match_a_irq_en;
  logic                overflow_irq_en;
  logic                match_b_flag;
  logic                match_a_flag;
  logic                overflow_flag;
  logic                block_q;
  tmr8_pkg::tmr8_dir_t dir_q;
  logic [7:0]          rdata_q;
  logic                wave_a_q;
  logic                wave_b_q;

  // ==========================================================
  // decode
  wire       tick;
  wire [2:0] wave_mode_field = {wave_mode_bit2, wave_mode_lo};
  wire       pwm_mode        = wave_mode_field[0];
  wire       fast_mode       = pwm_mode & wave_mode_lo[1];
  wire       phase_mode      = pwm_mode & ~wave_mode_lo[1];
  wire       top_is_cmp      = (wave_mode_field == tmr8_pkg::WGM_CTC) |
                               (wave_mode_field == tmr8_pkg::WGM_PC_OCRA) |
                               (wave_mode_field == tmr8_pkg::WGM_FP_OCRA);
  wire [7:0] top_val         = top_is_cmp ? compare_value_a : tmr8_pkg::CNT_MAX;
  wire       wr_ctrl_a       = wr & (addr == tmr8_pkg::OFS_CTRL_A);
  wire       wr_ctrl_b       = wr & (addr == tmr8_pkg::OFS_CTRL_B);
  wire       wr_count        = wr & (addr == tmr8_pkg::OFS_COUNT);
  wire       wr_cmp_a        = wr & (addr == tmr8_pkg::OFS_CMP_A);
  wire       wr_cmp_b        = wr & (addr == tmr8_pkg::OFS_CMP_B);
  wire       wr_mask         = wr & (addr == tmr8_pkg::OFS_MASK);
  wire       wr_flags        = wr & (addr == tmr8_pkg::OFS_FLAGS);
  wire       at_top          = timer_count == top_val;
  wire       at_bottom       = timer_count == tmr8_pkg::CNT_BOTTOM;
  wire       counting_down   = dir_q == tmr8_pkg::TMR8_DOWN;

  // forced compares never reach the flag or counter logic
  wire force_a = wr_ctrl_b & wdata[tmr8_pkg::FOC_A_BIT] & ~pwm_mode; // RQ1 RQ3
  wire force_b = wr_ctrl_b & wdata[tmr8_pkg::FOC_B_BIT] & ~pwm_mode; // RQ1 RQ3

  // real matches, suppressed on the tick following a counter write
  wire match_a_ev = tick & ~block_q & (timer_count == compare_value_a); // RQ10 RQ11
  wire match_b_ev = tick & ~block_q & (timer_count == compare_value_b); // RQ10 RQ11

  // counter wrap in fast modes doubles as the bottom event for the outputs
  wire wrap_ev = tick & fast_mode & at_top;

  // overflow point per waveform mode
  wire ovf_ev = tick & (phase_mode ? (counting_down & at_bottom) :          // RQ19 RQ20
                        (wave_mode_field == tmr8_pkg::WGM_FP_OCRA) ? at_top :
                        (timer_count == tmr8_pkg::CNT_MAX));

  // ==========================================================
  // next waveform level for one channel
  function automatic logic wave_next(
    input logic       cur,
    input logic [1:0] act,
    input logic       is_a,
    input logic       match,
    input logic       bottom
  );
    logic v;
    v = cur;
    if (!pwm_mode) begin
      if (match) begin
        unique case (act)
          tmr8_pkg::ACT_OFF:    v = cur;
          tmr8_pkg::ACT_TOGGLE: v = ~cur;
          tmr8_pkg::ACT_CLEAR:  v = 1'b0;
          tmr8_pkg::ACT_SET:    v = 1'b1;
        endcase
      end
    end else begin
      if (match) begin
        unique case (act)
          tmr8_pkg::ACT_OFF:    v = cur;
          tmr8_pkg::ACT_TOGGLE: v = (is_a & wave_mode_bit2) ? ~cur : cur;
          tmr8_pkg::ACT_CLEAR:  v = (phase_mode & counting_down) ? 1'b1 : 1'b0;
          tmr8_pkg::ACT_SET:    v = (phase_mode & counting_down) ? 1'b0 : 1'b1;
        endcase
      end
      // bottom action comes last so it wins when compare equals top
      if (bottom & (act == tmr8_pkg::ACT_CLEAR)) begin
        v = 1'b1;
      end else if (bottom & (act == tmr8_pkg::ACT_SET)) begin
        v = 1'b0;
      end
    end
    return v;
  endfunction : wave_next

  wire wave_a_d = wave_next(wave_a_q, out_action_a, 1'b1, match_a_ev | force_a, wrap_ev); // RQ2
  wire wave_b_d = wave_next(wave_b_q, out_action_b, 1'b0, match_b_ev | force_b, wrap_ev); // RQ2

  // ==========================================================
  // clock source
  tmr8_prescale u_prescale (
    .clk            (clk),
    .rst_n          (rst_n),
    .clk_en         (clk_en),
    .clk_source_sel (clk_source_sel),
    .ext_count_pin  (ext_count_pin),
    .tick           (tick)
  );

  // ==========================================================
  // counter
  logic [7:0]          count_d;
  tmr8_pkg::tmr8_dir_t dir_d;

  always_comb begin
    count_d = timer_count;
    dir_d   = dir_q;
    if (wr_count) begin
      count_d = wdata; // RQ9
    end else if (tick) begin // RQ21
      if (phase_mode) begin
        if (!counting_down && at_top) begin
          dir_d   = tmr8_pkg::TMR8_DOWN;
          count_d = timer_count - 8'h01;
        end else if (counting_down && at_bottom) begin
          dir_d   = tmr8_pkg::TMR8_UP;
          count_d = timer_count + 8'h01;
        end else begin
          count_d = counting_down ? timer_count - 8'h01 : timer_count + 8'h01;
        end
      end else if (at_top) begin
        count_d = tmr8_pkg::CNT_BOTTOM;
      end else begin
        count_d = timer_count + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_count <= tmr8_pkg::REG_RESET;
      dir_q       <= tmr8_pkg::TMR8_UP;
      block_q     <= 1'b0;
    end else if (clk_en) begin
      timer_count <= count_d;
      dir_q       <= dir_d;
      block_q     <= wr_count | (block_q & ~tick); // RQ10
    end
  end

  // ==========================================================
  // control and compare registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_action_a    <= tmr8_pkg::ACT_OFF;
      out_action_b    <= tmr8_pkg::ACT_OFF;
      wave_mode_lo    <= 2'h0;
      wave_mode_bit2  <= 1'b0;
      clk_source_sel  <= tmr8_pkg::CS_STOP;
      compare_value_a <= tmr8_pkg::REG_RESET;
      compare_value_b <= tmr8_pkg::REG_RESET;
      match_b_irq_en  <= 1'b0;
      match_a_irq_en  <= 1'b0;
      overflow_irq_en <= 1'b0;
    end else if (clk_en) begin
      if (wr_ctrl_a) begin
        out_action_a <= wdata[tmr8_pkg::ACT_A_LSB +: 2];
        out_action_b <= wdata[tmr8_pkg::ACT_B_LSB +: 2];
        wave_mode_lo <= wdata[tmr8_pkg::WGM10_LSB +: 2];
      end
      if (wr_ctrl_b) begin
        wave_mode_bit2 <= wdata[tmr8_pkg::WGM2_BIT];
        clk_source_sel <= wdata[tmr8_pkg::CS_LSB +: 3]; // RQ6
      end
      if (wr_cmp_a) begin
        compare_value_a <= wdata;
      end
      if (wr_cmp_b) begin
        compare_value_b <= wdata;
      end
      if (wr_mask) begin
        match_b_irq_en  <= wdata[tmr8_pkg::MB_BIT];
        match_a_irq_en  <= wdata[tmr8_pkg::MA_BIT];
        overflow_irq_en <= wdata[tmr8_pkg::OVF_BIT];
      end
    end
  end

  // ==========================================================
  // flags: a set in the clearing cycle wins
  wire clr_b   = ack_match_b | (wr_flags & wdata[tmr8_pkg::MB_BIT]);
  wire clr_a   = ack_match_a | (wr_flags & wdata[tmr8_pkg::MA_BIT]);
  wire clr_ovf = ack_overflow | (wr_flags & wdata[tmr8_pkg::OVF_BIT]);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      match_b_flag  <= 1'b0;
      match_a_flag  <= 1'b0;
      overflow_flag <= 1'b0;
    end else if (clk_en) begin
      match_b_flag  <= match_b_ev | (match_b_flag & ~clr_b);    // RQ16 RQ22
      match_a_flag  <= match_a_ev | (match_a_flag & ~clr_a);    // RQ17 RQ22
      overflow_flag <= ovf_ev | (overflow_flag & ~clr_ovf);     // RQ18 RQ22
    end
  end

  assign irq_match_b  = match_b_irq_en & global_irq_en & match_b_flag;   // RQ13
  assign irq_match_a  = match_a_irq_en & global_irq_en & match_a_flag;   // RQ14
  assign irq_overflow = overflow_irq_en & global_irq_en & overflow_flag; // RQ15

  // ==========================================================
  // waveform outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wave_a_q <= 1'b0;
      wave_b_q <= 1'b0;
    end else if (clk_en) begin
      wave_a_q <= wave_a_d;
      wave_b_q <= wave_b_d;
    end
  end

  assign wave_out_a = wave_a_q;
  assign wave_out_b = wave_b_q;
  assign wave_oe_a  = out_action_a != tmr8_pkg::ACT_OFF;
  assign wave_oe_b  = out_action_b != tmr8_pkg::ACT_OFF;

  // ==========================================================
  // read path
  wire [7:0] rd_ctrl_a = {out_action_a, out_action_b, 2'h0, wave_mode_lo};
  wire [7:0] rd_ctrl_b = {4'h0, wave_mode_bit2, clk_source_sel};             // RQ4 RQ12
  wire [7:0] rd_mask   = {5'h00, match_b_irq_en, match_a_irq_en, overflow_irq_en}; // RQ12
  wire [7:0] rd_flags  = {5'h00, match_b_flag, match_a_flag, overflow_flag};       // RQ12
  wire [7:0] rd_val    = (addr == tmr8_pkg::OFS_CTRL_A) ? rd_ctrl_a :
                         (addr == tmr8_pkg::OFS_CTRL_B) ? rd_ctrl_b :
                         (addr == tmr8_pkg::OFS_COUNT)  ? timer_count :
                         (addr == tmr8_pkg::OFS_CMP_A)  ? compare_value_a :
                         (addr == tmr8_pkg::OFS_CMP_B)  ? compare_value_b :
                         (addr == tmr8_pkg::OFS_MASK)   ? rd_mask :
                         (addr == tmr8_pkg::OFS_FLAGS)  ? rd_flags : 8'h00;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (clk_en) begin
      rdata_q <= rd ? rd_val : 8'h00;
    end
  end

  assign rdata = rdata_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_force_a_pwm;
    clk_en && wr_ctrl_b && wdata[tmr8_pkg::FOC_A_BIT] && pwm_mode && !tick;
  endsequence

  sequence s_force_a_toggle;
    clk_en && wr_ctrl_b && wdata[tmr8_pkg::FOC_A_BIT] && !pwm_mode && !wdata[0] &&
      out_action_a == tmr8_pkg::ACT_TOGGLE && !match_a_ev;
  endsequence

  sequence s_force_quiet;
    clk_en && wr_ctrl_b && (wdata[tmr8_pkg::FOC_A_BIT] || wdata[tmr8_pkg::FOC_B_BIT]) && !tick &&
      !clr_a && !clr_b && !clr_ovf;
  endsequence

  a_force_pwm_ignored: assert property (s_force_a_pwm |=> $stable(wave_out_a)) // RQ1
    else $error("force strobe changed output in pwm mode");

  a_force_toggle_out: assert property (s_force_a_toggle |=> wave_out_a != $past(wave_out_a)) // RQ2
    else $error("force strobe did not toggle output");

  a_force_no_flag: assert property (s_force_quiet |=> $stable({match_a_flag, match_b_flag, overflow_flag}) &&
                                    timer_count == $past(timer_count)) // RQ3
    else $error("force strobe touched flags or counter");

  a_ctrl_b_read: assert property (clk_en && rd && addr == tmr8_pkg::OFS_CTRL_B |=> rdata[7:4] == 4'h0) // RQ4
    else $error("force or reserved bits read nonzero");

  a_stop_holds: assert property (clk_en && clk_source_sel == tmr8_pkg::CS_STOP && !wr_count
                                 |=> timer_count == $past(timer_count)) // RQ21
    else $error("stopped counter moved");

  a_write_blocks: assert property (clk_en && wr_count ##1 !match_a_flag |=> !match_a_flag) // RQ10
    else $error("match flagged on tick after counter write");

  a_mask_reserved: assert property (clk_en && rd && addr == tmr8_pkg::OFS_MASK |=> rdata[7:3] == 5'h00) // RQ12
    else $error("mask reserved bits nonzero");

  a_irq_a_cause: assert property (irq_match_a |-> match_a_flag && match_a_irq_en && global_irq_en) // RQ14
    else $error("match a request without cause");

  a_ack_clears: assert property (clk_en && ack_match_b && !match_b_ev |=> !match_b_flag) // RQ22
    else $error("acknowledge did not clear match b flag");

  a_ovf_at_max: assert property (clk_en && tick && !pwm_mode && !wr_count && timer_count == tmr8_pkg::CNT_MAX
                                 |=> overflow_flag && timer_count == tmr8_pkg::CNT_BOTTOM) // RQ20
    else $error("overflow missed at max in non-pwm mode");

  a_match_sets: assert property (clk_en && match_b_ev |=> match_b_flag) // RQ16
    else $error("match b event lost");

endmodule : tmr8_top

// [test/tmr8_cpu_model.sv]
`timescale 1ns/100ps
module tmr8_cpu_model (
  input  wire logic       clk,
  output logic      [7:0] addr,
  output logic      [7:0] wdata,
  output logic            wr,
  output logic            rd,
  input  wire logic [7:0] rdata,
  output logic            ack_overflow,
  output logic            ack_match_a,
  output logic            ack_match_b
);
  logic keep_rules = 1'b1;
  logic pwm_q      = 1'b0;
  initial begin
    {addr, wdata, wr, rd} = 18'h0;
    {ack_match_b, ack_match_a, ack_overflow} = 3'h0;
  end
  // ==========================================================
  // bus cycles
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == tmr8_pkg::OFS_CTRL_A) pwm_q = d[0];
    if (keep_rules && pwm_q && a == tmr8_pkg::OFS_CTRL_B) v[7:6] = 2'h0;
    @(posedge clk);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask : rd_reg
  // vector entry: one-cycle acknowledge per source
  task automatic ack(input logic [2:0] m);
    @(posedge clk);
    {ack_match_b, ack_match_a, ack_overflow} <= m;
    @(posedge clk);
    {ack_match_b, ack_match_a, ack_overflow} <= 3'h0;
  endtask : ack
endmodule : tmr8_cpu_model

// [test/tb_top.sv]
`timescale 1ns/100ps
module tb_top;
  logic        clk           = 1'b0;
  logic        nrst          = 1'b0;
  logic        ext_count_pin = 1'b0;
  logic        global_irq_en = 1'b0;
  logic [7:0]  addr, wdata, rdata, r, c0, c1;
  logic        wr, rd, ack_ovf, ack_ma, ack_mb, irq_ovf, irq_ma, irq_mb, wave_a, wave_b, oe_a, oe_b;
  logic [31:0] seed          = 32'h8581b8f9;
  int          n_errors      = 0;
  int          check_count   = 0;
  int          sel;
  logic [7:0]  ofs   [6] = '{tmr8_pkg::OFS_CTRL_B, tmr8_pkg::OFS_COUNT, tmr8_pkg::OFS_CMP_A,
                            tmr8_pkg::OFS_CMP_B, tmr8_pkg::OFS_MASK, tmr8_pkg::OFS_FLAGS};
  logic [7:0]  wmask [6] = '{8'hc8, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff};
  logic [7:0]  rmask [6] = '{8'h08, 8'hff, 8'hff, 8'hff, 8'h07, 8'h00};
  int          divs  [6] = '{0, 1, 8, 64, 256, 1024};

  always #5 clk = ~clk;

  tmr8_top u_dut (
    .clk(clk), .nrst(nrst), .clk_en(1'b1), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .ext_count_pin(ext_count_pin), .global_irq_en(global_irq_en), .ack_overflow(ack_ovf),
    .ack_match_a(ack_ma), .ack_match_b(ack_mb), .irq_overflow(irq_ovf), .irq_match_a(irq_ma),
    .irq_match_b(irq_mb), .wave_out_a(wave_a), .wave_out_b(wave_b), .wave_oe_a(oe_a), .wave_oe_b(oe_b)
  );
  tmr8_cpu_model u_cpu (
    .clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .ack_overflow(ack_ovf), .ack_match_a(ack_ma), .ack_match_b(ack_mb)
  );

  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [7:0] edge_cnt(input int s, input logic lv);
    return {7'h0, (s == 7 && lv) || (s == 6 && !lv)};
  endfunction : edge_cnt
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    u_cpu.wr_reg(a, d);
  endtask : w
  task automatic irq_chk(input logic [2:0] exp);
    @(negedge clk);
    check("irq", {5'h0, irq_mb, irq_ma, irq_ovf}, {5'h0, exp});
  endtask : irq_chk
  task automatic give_verdict();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    give_verdict();
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    foreach (ofs[i]) begin
      u_cpu.rd_reg(ofs[i], r);
      check("reset value", r, 8'h00);
    end
    repeat (4) begin
      foreach (ofs[i]) begin
        seed = lfsr(seed);
        w(ofs[i], seed[7:0] & wmask[i]);
        u_cpu.rd_reg(ofs[i], r);
        check("read back", r, seed[7:0] & wmask[i] & rmask[i]);
      end
    end
    // count rate per internal source, then hold when stopped
    for (sel = 1; sel <= 5; sel++) begin
      w(tmr8_pkg::OFS_COUNT, 8'h00);
      w(tmr8_pkg::OFS_CTRL_B, 8'(sel));
      repeat (20 * divs[sel]) @(posedge clk);
      w(tmr8_pkg::OFS_CTRL_B, 8'h00);
      u_cpu.rd_reg(tmr8_pkg::OFS_COUNT, r);
      check("rate", {7'h0, r >= 8'h12 && r <= 8'h16}, 8'h01);
      repeat (5) @(posedge clk);
      u_cpu.rd_reg(tmr8_pkg::OFS_COUNT, c0);
      check("hold", c0, r);
    end
    // external pin: one rising then one falling edge per source
    for (sel = 6; sel <= 7; sel++) begin
      w(tmr8_pkg::OFS_CTRL_B, 8'(sel));
      for (int lv = 1; lv >= 0; lv--) begin
        u_cpu.rd_reg(tmr8_pkg::OFS_COUNT, c0);
        ext_count_pin <= lv[0];
        repeat (10) @(posedge clk);
        u_cpu.rd_reg(tmr8_pkg::OFS_COUNT, c1);
        check("pin edge", c1 - c0, edge_cnt(sel, lv[0]));
      end
      w(tmr8_pkg::OFS_CTRL_B, 8'h00);
    end
    // flags across a wrap, cleared by write-one and by acknowledge
    w(tmr8_pkg::OFS_FLAGS, 8'h07);
    w(tmr8_pkg::OFS_COUNT, 8'hfd);
    w(tmr8_pkg::OFS_CMP_A, 8'hfe);
    w(tmr8_pkg::OFS_CMP_B, 8'h02);
    w(tmr8_pkg::OFS_MASK, 8'h07);
    global_irq_en <= 1'b1;
    w(tmr8_pkg::OFS_CTRL_B, {5'h0, tmr8_pkg::CS_DIRECT});
    repeat (6) @(posedge clk);
    w(tmr8_pkg::OFS_CTRL_B, 8'h00);
    u_cpu.rd_reg(tmr8_pkg::OFS_FLAGS, r);
    check("flags set", r, 8'h07);
    irq_chk(3'h7);
    w(tmr8_pkg::OFS_FLAGS, 8'h02);
    u_cpu.rd_reg(tmr8_pkg::OFS_FLAGS, r);
    check("write one", r, 8'h05);
    irq_chk(3'h5);
    u_cpu.ack(3'h1);
    u_cpu.rd_reg(tmr8_pkg::OFS_FLAGS, r);
    check("ack ovf", r, 8'h04);
    irq_chk(3'h4);
    global_irq_en <= 1'b0;
    irq_chk(3'h0);
    u_cpu.ack(3'h4);
    u_cpu.rd_reg(tmr8_pkg::OFS_FLAGS, r);
    check("ack b", r, 8'h00);
    // count write while running hides the next match; top bit cleared so no overflow
    seed = lfsr(seed);
    c1 = seed[7:0] & 8'h7f;
    w(tmr8_pkg::OFS_CMP_A, c1);
    w(tmr8_pkg::OFS_CMP_B, c1);
    w(tmr8_pkg::OFS_COUNT, c1 + 8'h64);
    w(tmr8_pkg::OFS_CTRL_B, {5'h0, tmr8_pkg::CS_DIRECT});
    w(tmr8_pkg::OFS_COUNT, c1);
    w(tmr8_pkg::OFS_CTRL_B, 8'h00);
    u_cpu.rd_reg(tmr8_pkg::OFS_FLAGS, r);
    check("blocked match", r, 8'h00);
    // forced compare in clear-on-match mode, then ignored in pwm
    u_cpu.rd_reg(tmr8_pkg::OFS_COUNT, c0);
    w(tmr8_pkg::OFS_CMP_A, c0);
    w(tmr8_pkg::OFS_CTRL_A, 8'h72);
    w(tmr8_pkg::OFS_CTRL_B, 8'hc0);
    u_cpu.rd_reg(tmr8_pkg::OFS_COUNT, r);
    check("force count", r, c0);
    check("force wave", {6'h0, wave_b, wave_a}, 8'h03);
    check("wave enable", {6'h0, oe_b, oe_a}, 8'h03);
    u_cpu.rd_reg(tmr8_pkg::OFS_FLAGS, r);
    check("force flags", r, 8'h00);
    u_cpu.keep_rules = 1'b0;
    w(tmr8_pkg::OFS_CTRL_A, 8'ha3);
    w(tmr8_pkg::OFS_CTRL_B, 8'hc0);
    u_cpu.rd_reg(tmr8_pkg::OFS_CTRL_B, r);
    check("force reads zero", r, 8'h00);
    check("pwm force", {6'h0, wave_b, wave_a}, 8'h03);
    // phase correct, top from compare a: up to 4, down to bottom, overflow there
    w(tmr8_pkg::OFS_CTRL_A, 8'h01);
    w(tmr8_pkg::OFS_CMP_A, 8'h04);
    w(tmr8_pkg::OFS_CMP_B, 8'h04);
    w(tmr8_pkg::OFS_COUNT, 8'h02);
    w(tmr8_pkg::OFS_CTRL_B, 8'h09);
    repeat (6) @(posedge clk);
    w(tmr8_pkg::OFS_CTRL_B, 8'h00);
    u_cpu.rd_reg(tmr8_pkg::OFS_COUNT, r);
    check("phase count", r, 8'h02);
    u_cpu.rd_reg(tmr8_pkg::OFS_FLAGS, r);
    check("phase flags", r, 8'h07);
    give_verdict();
  end
endmodule : tb_top
